// ==== design/otl_overtravel_limit.sv ====
// Overtravel limit control: limit inputs, stop sequencing, warning flag, APB registers.
// Assumes all inputs synchronous to i_clk and an APB master on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "otl_defs.svh"

module otl_overtravel_limit #(
    parameter int FORCE_W = 10
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [11:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_fwd_limit_in,
    input wire logic i_rev_limit_in,
    input wire logic i_power_on,
    input wire logic i_force_ctrl,
    input wire logic i_ref_fwd,
    input wire logic i_ref_rev,
    input wire logic i_motor_stopped,
    input wire logic i_brake_req,
    input wire logic [9:0] i_motor_max_force,
    output logic o_fwd_allow,
    output logic o_rev_allow,
    output logic o_fwd_ot,
    output logic o_rev_ot,
    output logic [1:0] o_stop_action,
    output logic o_zero_clamp,
    output logic o_coast,
    output logic [9:0] o_estop_force,
    output logic o_ot_warning,
    output logic o_brake_release_out
);
    import otl_pkg::*;

    typedef struct packed {
        logic fwd_s;
        logic rev_s;
        logic [3:0] fwd_cfg;
        logic [3:0] rev_cfg;
        logic [7:0] stop_sel;
        logic [3:0] fwd_act;
        logic [3:0] rev_act;
        logic [7:0] stop_act;
        logic [9:0] estop;
        logic [3:0] warn_cfg;
        logic swlim;
        logic warn;
        logic block;
        logic pwr_d;
        logic ot_at_pwr;
        otl_state_t st;
        otl_after_t after;
        logic [7:0] settle;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic fwd_allow;
        logic rev_allow;
        logic fwd_ot;
        logic rev_ot;
        otl_act_t act;
        logic [9:0] force_o;
        logic brake;
        logic clamp_o;
        logic coast_o;
    } otl_regs_t;

    otl_regs_t q_r;
    otl_regs_t q_nxt;

    function automatic logic [9:0] otl_min10(input logic [9:0] a, input logic [9:0] b);
        otl_min10 = (a < b) ? a : b;
    endfunction

    logic fwd_ot_c;
    logic rev_ot_c;
    logic any_ot;
    logic wr_en;
    logic rd_en;
    logic raise;
    logic [7:0] settle_max;
    logic warn_ok;
    logic clr_cmd;

    assign settle_max = 8'(`OTL_STOP_SETTLE_CYC);
    // Inputs are registered once so a single-cycle dropout is still seen.
    assign fwd_ot_c = (q_r.fwd_act != `OTL_LIM_OFF) && !q_r.fwd_s;
    assign rev_ot_c = (q_r.rev_act != `OTL_LIM_OFF) && !q_r.rev_s;
    assign any_ot = fwd_ot_c || rev_ot_c;
    assign wr_en = i_psel && i_penable && i_pwrite && !q_r.pready;
    assign rd_en = i_psel && i_penable && !i_pwrite && !q_r.pready;
    // Helpers for the warning checks below; kept apart from the update logic on purpose.
    assign warn_ok = (q_r.warn_cfg == 4'h1) && i_power_on && q_r.pwr_d && !q_r.ot_at_pwr;
    assign clr_cmd = wr_en && (i_paddr == `OTL_ADDR_CTRL) && i_pwdata[`OTL_CTRL_CLEAR];

    always_comb begin
        q_nxt = q_r;
        q_nxt.fwd_s = i_fwd_limit_in;
        q_nxt.rev_s = i_rev_limit_in;
        q_nxt.pready = i_psel && i_penable && !q_r.pready;
        q_nxt.pslverr = 1'b0;

        if (wr_en) begin
            case (i_paddr)
                `OTL_ADDR_FWD_CFG: q_nxt.fwd_cfg = i_pwdata[3:0];
                `OTL_ADDR_REV_CFG: q_nxt.rev_cfg = i_pwdata[3:0];
                `OTL_ADDR_STOP_SEL: q_nxt.stop_sel = i_pwdata[7:0];
                // Out-of-range force writes saturate at the top of the scale.
                `OTL_ADDR_ESTOP: q_nxt.estop = (i_pwdata > 32'(`OTL_ESTOP_MAX)) ?
                    `OTL_ESTOP_MAX : i_pwdata[9:0];
                `OTL_ADDR_WARN_CFG: q_nxt.warn_cfg = i_pwdata[3:0];
                `OTL_ADDR_CTRL: begin
                    q_nxt.swlim = i_pwdata[`OTL_CTRL_SWLIM];
                    if (i_pwdata[`OTL_CTRL_RESTART]) begin
                        // Setup fields load only on restart.
                        q_nxt.fwd_act = q_r.fwd_cfg;
                        q_nxt.rev_act = q_r.rev_cfg;
                        q_nxt.stop_act = q_r.stop_sel;
                    end
                end
                `OTL_ADDR_STATUS, `OTL_ADDR_WCODE: ;
                default: q_nxt.pslverr = 1'b1;
            endcase
        end
        if (rd_en) begin
            case (i_paddr)
                `OTL_ADDR_FWD_CFG: q_nxt.prdata = {28'h0000000, q_r.fwd_cfg};
                `OTL_ADDR_REV_CFG: q_nxt.prdata = {28'h0000000, q_r.rev_cfg};
                `OTL_ADDR_STOP_SEL: q_nxt.prdata = {24'h000000, q_r.stop_sel};
                `OTL_ADDR_ESTOP: q_nxt.prdata = {22'h0, q_r.estop};
                `OTL_ADDR_WARN_CFG: q_nxt.prdata = {28'h0000000, q_r.warn_cfg};
                `OTL_ADDR_CTRL: q_nxt.prdata = {29'h0, q_r.swlim, 2'b00};
                `OTL_ADDR_STATUS: q_nxt.prdata = {26'h0, q_r.act == OTL_ACT_COAST,
                    q_r.after == OTL_AFTER_CLAMP, q_r.st == OTL_ST_STOP,
                    q_r.warn, q_r.rev_ot, q_r.fwd_ot};
                `OTL_ADDR_WCODE: q_nxt.prdata = {20'h00000, q_r.warn ? 12'h9a0 : 12'h000};
                default: begin
                    q_nxt.prdata = 32'h00000000;
                    q_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // Overtravel present at power-on is remembered and never warned about.
        q_nxt.pwr_d = i_power_on;
        if (i_power_on && !q_r.pwr_d) begin
            q_nxt.ot_at_pwr = any_ot;
        end else if (!any_ot) begin
            q_nxt.ot_at_pwr = 1'b0;
        end

        raise = 1'b0;
        if (q_r.warn_cfg == 4'h1 && i_power_on && q_r.pwr_d && !q_r.ot_at_pwr) begin
            if (i_ref_fwd || i_ref_rev) begin
                raise = (i_ref_fwd && fwd_ot_c) || (i_ref_rev && rev_ot_c);
            end else begin
                raise = any_ot;
            end
            raise = raise || q_r.swlim;
        end
        if (!any_ot && !q_r.swlim) begin
            q_nxt.block = 1'b0;
        end
        // A clear in the same cycle as a set wins, since the clear always blocks it.
        if (wr_en && i_paddr == `OTL_ADDR_CTRL && i_pwdata[`OTL_CTRL_CLEAR]) begin
            q_nxt.warn = 1'b0;
            q_nxt.block = any_ot || q_r.swlim;
        end
        if (raise && !q_r.block && !q_nxt.block) begin
            q_nxt.warn = 1'b1;
        end

        // Stop sequencing; the warning takes no part in it.
        q_nxt.fwd_ot = fwd_ot_c;
        q_nxt.rev_ot = rev_ot_c;
        q_nxt.fwd_allow = !fwd_ot_c;
        q_nxt.rev_allow = !rev_ot_c;
        case (q_r.st)
            OTL_ST_RUN: begin
                q_nxt.act = OTL_ACT_RUN;
                q_nxt.after = OTL_AFTER_NONE;
                if ((fwd_ot_c && i_ref_fwd) || (rev_ot_c && i_ref_rev)) begin
                    q_nxt.st = OTL_ST_STOP;
                    q_nxt.settle = 8'h00;
                    if (!i_force_ctrl && (q_r.stop_act[7:4] == 4'h1 ||
                            q_r.stop_act[7:4] == 4'h2)) begin
                        q_nxt.act = OTL_ACT_DECEL;
                    end else if (q_r.stop_act[3:0] == 4'h2) begin
                        q_nxt.act = OTL_ACT_COAST;
                    end else begin
                        q_nxt.act = OTL_ACT_DB;
                    end
                end
            end
            OTL_ST_STOP: begin
                q_nxt.settle = i_motor_stopped ?
                    ((q_r.settle == settle_max) ? q_r.settle : q_r.settle + 8'h01) : 8'h00;
                if (q_r.settle == settle_max) begin
                    q_nxt.st = OTL_ST_HOLD;
                    if (q_r.act == OTL_ACT_DECEL && q_r.stop_act[7:4] == 4'h1) begin
                        q_nxt.after = OTL_AFTER_CLAMP;
                        q_nxt.act = OTL_ACT_RUN;
                    end else if (q_r.act == OTL_ACT_DB && q_r.stop_act[3:0] == 4'h0 &&
                            !i_force_ctrl) begin
                        q_nxt.after = OTL_AFTER_NONE;
                    end else begin
                        q_nxt.after = OTL_AFTER_COAST;
                        q_nxt.act = OTL_ACT_COAST;
                    end
                end
            end
            OTL_ST_HOLD: begin
                if (!any_ot) begin
                    q_nxt.st = OTL_ST_RUN;
                end
            end
            default: q_nxt.st = OTL_ST_RUN;
        endcase
        q_nxt.force_o = otl_min10(q_r.estop, i_motor_max_force);
        q_nxt.brake = i_brake_req || (any_ot && i_power_on);
        // Decoded here so the clamp and coast pins leave straight from flops.
        q_nxt.clamp_o = (q_nxt.after == OTL_AFTER_CLAMP);
        q_nxt.coast_o = (q_nxt.after == OTL_AFTER_COAST);
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            q_r <= '0;
            q_r.fwd_s <= 1'b1;
            q_r.rev_s <= 1'b1;
            q_r.fwd_cfg <= `OTL_FWD_USE;
            q_r.rev_cfg <= `OTL_REV_USE;
            q_r.fwd_act <= `OTL_FWD_USE;
            q_r.rev_act <= `OTL_REV_USE;
            q_r.stop_sel <= `OTL_STOP_DEFAULT;
            q_r.stop_act <= `OTL_STOP_DEFAULT;
            q_r.estop <= `OTL_ESTOP_DEFAULT;
            q_r.warn_cfg <= `OTL_WARN_DEFAULT;
            q_r.fwd_allow <= 1'b1;
            q_r.rev_allow <= 1'b1;
            q_r.st <= OTL_ST_RUN;
            q_r.act <= OTL_ACT_RUN;
            q_r.after <= OTL_AFTER_NONE;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_prdata = q_r.prdata;
    assign o_pready = q_r.pready;
    assign o_pslverr = q_r.pslverr;
    assign o_fwd_allow = q_r.fwd_allow;
    assign o_rev_allow = q_r.rev_allow;
    assign o_fwd_ot = q_r.fwd_ot;
    assign o_rev_ot = q_r.rev_ot;
    assign o_stop_action = q_r.act;
    assign o_zero_clamp = q_r.clamp_o;
    assign o_coast = q_r.coast_o;
    assign o_estop_force = q_r.force_o;
    assign o_ot_warning = q_r.warn;
    assign o_brake_release_out = q_r.brake;

    fwd_block_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.fwd_act != `OTL_LIM_OFF && !q_r.fwd_s) |=> !o_fwd_allow && o_fwd_ot)
        else $error("forward motion not blocked");
    rev_block_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.rev_act != `OTL_LIM_OFF && !q_r.rev_s) |=> !o_rev_allow && o_rev_ot)
        else $error("reverse motion not blocked");
    away_pass_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (fwd_ot_c && !rev_ot_c) |=> o_rev_allow)
        else $error("motion away from limit blocked");
    fwd_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.fwd_act == `OTL_LIM_OFF) |=> !o_fwd_ot)
        else $error("disabled forward limit tripped");
    rev_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.rev_act == `OTL_LIM_OFF) |=> !o_rev_ot)
        else $error("disabled reverse limit tripped");
    no_decel_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_force_ctrl && q_r.st == OTL_ST_RUN) |=> o_stop_action != OTL_ACT_DECEL)
        else $error("deceleration under force control");
    force_cap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ##1 (o_estop_force <= $past(i_motor_max_force) && o_estop_force <= `OTL_ESTOP_MAX))
        else $error("emergency force above cap");
    warn_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!i_power_on && !q_r.warn) |=> !o_ot_warning)
        else $error("warning raised with power off");
    warn_disabled_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.warn_cfg == 4'h0 && !q_r.warn) |=> !o_ot_warning)
        else $error("warning raised while disabled");
    brake_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (any_ot && i_power_on) |=> o_brake_release_out)
        else $error("brake applied during overtravel");

    // Stop selection: the choice is made on the edge that enters the stopping state.
    coast_pick_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.st == OTL_ST_RUN && fwd_ot_c && i_ref_fwd && q_r.stop_act == 8'h02)
        |=> o_stop_action == OTL_ACT_COAST)
        else $error("coast stop not selected");
    decel_pick_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.st == OTL_ST_RUN && !i_force_ctrl && fwd_ot_c && i_ref_fwd &&
            (q_r.stop_act[7:4] == 4'h1 || q_r.stop_act[7:4] == 4'h2))
        |=> o_stop_action == OTL_ACT_DECEL)
        else $error("deceleration stop not selected");
    clamp_after_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.st == OTL_ST_STOP && q_r.settle == settle_max && q_r.act == OTL_ACT_DECEL &&
            q_r.stop_act[7:4] == 4'h1)
        |=> o_zero_clamp && !o_coast)
        else $error("zero clamp not entered after stop");
    force_coast_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.st == OTL_ST_STOP && q_r.settle == settle_max && i_force_ctrl &&
            q_r.act != OTL_ACT_DECEL)
        |=> o_coast && !o_zero_clamp)
        else $error("no coast after stop under force control");
    warn_raise_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (warn_ok && !q_r.block && !clr_cmd && i_ref_fwd && fwd_ot_c)
        |=> o_ot_warning)
        else $error("overtravel warning not raised");
    warn_cross_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (warn_ok && i_ref_fwd && !i_ref_rev && rev_ot_c && !fwd_ot_c && !q_r.swlim &&
            !q_r.warn)
        |=> !o_ot_warning)
        else $error("warning raised against the reference");
    warn_any_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (warn_ok && !i_ref_fwd && !i_ref_rev && any_ot && !q_r.block && !clr_cmd)
        |=> o_ot_warning)
        else $error("warning missing without a reference");
    power_edge_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_power_on && !q_r.pwr_d && !q_r.warn) |=> !o_ot_warning)
        else $error("warning raised at power on");
    warn_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        clr_cmd |=> !o_ot_warning)
        else $error("warning survived the clear command");
    warn_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.warn && !clr_cmd) |=> o_ot_warning)
        else $error("warning dropped without a clear");
    swlim_warn_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (warn_ok && q_r.swlim && !q_r.block && !clr_cmd)
        |=> o_ot_warning)
        else $error("software limit raised no warning");
    stop_start_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (q_r.st == OTL_ST_RUN && fwd_ot_c && i_ref_fwd)
        |=> o_stop_action != OTL_ACT_RUN)
        else $error("stop processing skipped");
    // A one-cycle dropout must still reach the status two edges later.
    pulse_catch_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!i_fwd_limit_in && q_r.fwd_act != `OTL_LIM_OFF &&
            !(wr_en && i_paddr == `OTL_ADDR_CTRL))
        |=> ##1 o_fwd_ot)
        else $error("short limit dropout lost");
endmodule // otl_overtravel_limit

`default_nettype wire

// ==== design/otl_defs.svh ====
// Offsets, field positions, reset values and timing counts of the overtravel limit block.
// Assumes inclusion by name from the design directory.
`ifndef OTL_DEFS_SVH
`define OTL_DEFS_SVH

`define OTL_ADDR_FWD_CFG 12'h000
`define OTL_ADDR_REV_CFG 12'h004
`define OTL_ADDR_STOP_SEL 12'h008
`define OTL_ADDR_ESTOP 12'h00c
`define OTL_ADDR_WARN_CFG 12'h010
`define OTL_ADDR_CTRL 12'h014
`define OTL_ADDR_STATUS 12'h018
`define OTL_ADDR_WCODE 12'h01c

`define OTL_FWD_USE 4'h1
`define OTL_REV_USE 4'h2
`define OTL_LIM_OFF 4'h8
`define OTL_STOP_DEFAULT 8'h00
`define OTL_ESTOP_DEFAULT 10'h320
`define OTL_ESTOP_MAX 10'h320
`define OTL_WARN_DEFAULT 4'h0

// Control word bits.
`define OTL_CTRL_RESTART 0
`define OTL_CTRL_CLEAR 1
`define OTL_CTRL_SWLIM 2

// Status word bits.
`define OTL_ST_FWD_OT 0
`define OTL_ST_REV_OT 1
`define OTL_ST_WARN 2
`define OTL_ST_STOPPING 3
`define OTL_ST_CLAMP 4
`define OTL_ST_COAST 5

// Motion is taken as stopped once the speed stays zero this long.
`define OTL_STOP_SETTLE_NS 100
`define OTL_STOP_SETTLE_CYC ((`OTL_STOP_SETTLE_NS + 4) / 5)

`endif

// ==== design/otl_pkg.sv ====
// Types shared by the overtravel limit block.
// Assumes otl_defs.svh is compiled alongside.
package otl_pkg;
    typedef enum logic [1:0] {
        OTL_ACT_RUN,
        OTL_ACT_DB,
        OTL_ACT_DECEL,
        OTL_ACT_COAST
    } otl_act_t;

    typedef enum logic [1:0] {
        OTL_ST_RUN,
        OTL_ST_STOP,
        OTL_ST_HOLD
    } otl_state_t;

    typedef enum logic [1:0] {
        OTL_AFTER_NONE,
        OTL_AFTER_COAST,
        OTL_AFTER_CLAMP
    } otl_after_t;
endpackage

// ==== verif/otl_limit_switch_model.sv ====
// Limit switch pair seen from the drive: normally closed contacts.
// Assumes trip requests from the bench, synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none

module otl_limit_switch_model (
    input wire logic i_clk,
    input wire logic i_trip_fwd,
    input wire logic i_trip_rev,
    output logic o_fwd_limit_in,
    output logic o_rev_limit_in
);
    // A closed contact allows motion, so a broken wire also reads as a trip.
    always_ff @(posedge i_clk) begin
        o_fwd_limit_in <= !i_trip_fwd;
        o_rev_limit_in <= !i_trip_rev;
    end
endmodule // otl_limit_switch_model

`default_nettype wire

// ==== verif/overtravel_limit_control_tb.sv ====
// Self-checking bench for the overtravel limit block.
// Assumes the design files and the limit switch model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module overtravel_limit_control_tb;
    logic i_clk, i_resetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic trip_f, trip_r, fwd_in, rev_in, pwr, fc, rf, rr, stp, brq;
    logic fa, ra, fo, ro, zc, co, wn, bk;
    logic [9:0] maxf, ef;
    logic [1:0] act;
    int num_errors, samples_checked, use_f, d;
    int cyc_cnt = 0;
    logic [11:0] r_adr[5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    logic [31:0] r_val[5] = '{32'h1, 32'h2, 32'h0, 32'h320, 32'h0};
    logic [7:0] s_sel[6] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h10};
    logic s_fc[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [1:0] s_act[6] = '{2'h1, 2'h1, 2'h3, 2'h2, 2'h2, 2'h1};
    logic s_cl[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic s_co[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

    otl_overtravel_limit u_otl_overtravel_limit (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_paddr(paddr), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_fwd_limit_in(fwd_in), .i_rev_limit_in(rev_in), .i_power_on(pwr),
        .i_force_ctrl(fc), .i_ref_fwd(rf), .i_ref_rev(rr), .i_motor_stopped(stp),
        .i_brake_req(brq), .i_motor_max_force(maxf), .o_fwd_allow(fa), .o_rev_allow(ra),
        .o_fwd_ot(fo), .o_rev_ot(ro), .o_stop_action(act), .o_zero_clamp(zc),
        .o_coast(co), .o_estop_force(ef), .o_ot_warning(wn), .o_brake_release_out(bk));

    otl_limit_switch_model u_otl_limit_switch_model (.i_clk(i_clk), .i_trip_fwd(trip_f),
        .i_trip_rev(trip_r), .o_fwd_limit_in(fwd_in), .o_rev_limit_in(rev_in));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // A hang in a handshake ends here rather than running forever.
    always @(posedge i_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Entered just after a rising edge; holds the request until pready is sampled.
    // Only the bench timeout ends a wait that never sees pready.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dt);
        paddr <= a;
        pwrite <= w;
        pwdata <= dt;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic restart;
        apb(12'h014, 1'b1, 32'h1);
        wt(2);
    endtask

    // The model predicts overtravel from the trip and the configuration in force.
    function automatic logic ot_exp(input int use_in, input logic trip);
        return (use_in != 0) && trip;
    endfunction

    initial begin
        {psel, penable, pwrite, trip_f, trip_r, pwr, fc, rf, rr, stp, brq} = '0;
        paddr = '0;
        pwdata = '0;
        maxf = 10'h3ff;
        i_resetn = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        d = 0;
        use_f = 1;
        void'($urandom(21));
        wt(16);
        i_resetn <= 1'b1;
        foreach (r_adr[k]) begin
            apb(r_adr[k], 1'b0, 32'h0);
            chk(rd, r_val[k]);
        end
        apb(12'h020, 1'b0, 32'h0);
        chk(er, 1'b1);
        pwr <= 1'b1;
        maxf <= 10'($urandom_range(799, 1));
        apb(12'h00c, 1'b1, 32'h384);
        apb(12'h00c, 1'b0, 32'h0);
        chk(rd, 32'h320);
        chk(ef, maxf);
        apb(12'h010, 1'b1, 32'h1);
        rf <= 1'b1;
        trip_f <= 1'b1;
        wt(5);
        chk({fo, fa, ra, wn, bk}, 5'b10111);
        apb(12'h01c, 1'b0, 32'h0);
        chk(rd, 32'h9a0);
        apb(12'h014, 1'b1, 32'h2);
        wt(3);
        chk(wn, 1'b0);
        trip_f <= 1'b0;
        wt(5);
        trip_f <= 1'b1;
        wt(5);
        chk(wn, 1'b1);
        trip_f <= 1'b0;
        apb(12'h014, 1'b1, 32'h2);
        trip_r <= 1'b1;
        wt(5);
        chk({ro, ra, fa, wn}, 4'b1010);
        trip_r <= 1'b0;
        rf <= 1'b0;
        repeat (4) begin
            d = $urandom % 2;
            wt(5);
            trip_f <= d[0];
            trip_r <= !d[0];
            wt(5);
            chk(wn, 1'b1);
            {trip_f, trip_r} <= 2'b00;
            wt(5);
            apb(12'h014, 1'b1, 32'h2);
        end
        // A one-cycle trip with no reference must still leave the warning set.
        trip_r <= 1'b1;
        wt(1);
        trip_r <= 1'b0;
        wt(5);
        chk(wn, 1'b1);
        apb(12'h014, 1'b1, 32'h2);
        pwr <= 1'b0;
        trip_f <= 1'b1;
        wt(5);
        chk(wn, 1'b0);
        pwr <= 1'b1;
        wt(5);
        chk({wn, fo}, 2'b01);
        trip_f <= 1'b0;
        wt(5);
        apb(12'h014, 1'b1, 32'h4);
        wt(3);
        chk(wn, 1'b1);
        apb(12'h014, 1'b1, 32'h2);
        apb(12'h010, 1'b1, 32'h0);
        apb(12'h000, 1'b1, 32'h8);
        trip_f <= 1'b1;
        wt(5);
        chk(fo, ot_exp(use_f, trip_f));
        restart();
        use_f = 0;
        wt(4);
        chk({fo, fa}, {ot_exp(use_f, trip_f), 1'b1});
        apb(12'h000, 1'b1, 32'h1);
        restart();
        trip_f <= 1'b0;
        foreach (s_sel[k]) begin
            apb(12'h008, 1'b1, 32'(s_sel[k]));
            restart();
            fc <= s_fc[k];
            rf <= 1'b1;
            trip_f <= 1'b1;
            wt(5);
            chk({act, wn}, {s_act[k], 1'b0});
            stp <= 1'b1;
            wt(25);
            chk(zc, s_cl[k]);
            chk(co, s_co[k]);
            {trip_f, stp} <= 2'b00;
            wt(5);
        end
        complete_run();
    end
endmodule // overtravel_limit_control_tb

`default_nettype wire
